// ### prl_pkg.sv
package prl_pkg;

  // apb map, byte addresses
  localparam int              ADDR_W       = 12;
  localparam logic [11:0]     OFF_LOCK     = 12'h000;
  localparam logic [11:0]     OFF_STATUS   = 12'h004;
  localparam logic [11:0]     OFF_IN_BASE  = 12'h100;
  localparam logic [11:0]     OFF_OUT_BASE = 12'h200;

  // sizes
  localparam int              N_IN         = 18;
  localparam int              N_PINA       = 6;
  localparam int              N_PINC       = 8;
  localparam int              N_PIN        = N_PINA + N_PINC;
  localparam int              N_WORD       = 32;
  localparam int              SEL_W        = 6;
  localparam int              OUT_W        = 5;

  // field layout
  localparam int              LOCK_BIT     = 0;
  localparam logic [5:0]      IN_SEL_MASK  = 6'h3f;
  localparam logic [5:0]      OUT_SEL_MASK = 6'h1f;
  localparam logic [5:0]      CODE_PORTC   = 6'h10;
  localparam logic [7:0]      UNLOCK_KEY1  = 8'h55;
  localparam logic [7:0]      UNLOCK_KEY2  = 8'haa;

  // input select slots that carry the two-wire bus clock and data
  localparam int              IDX_BUS_CLK  = 13;
  localparam int              IDX_BUS_DAT  = 14;

  // output source codes
  localparam logic [4:0]      OUT_REF_CLK  = 5'h1b;
  localparam logic [4:0]      OUT_TIMER0   = 5'h19;
  localparam logic [4:0]      OUT_CMP2     = 5'h14;
  localparam logic [4:0]      OUT_CELL1    = 5'h01;
  localparam logic [5:0]      OUT_RESET    = 6'h00;

  // default input pin codes after power-on, per variant
  localparam logic [0:N_IN-1][5:0] DEF_IN_LARGE = {
    6'h02, 6'h02, 6'h05, 6'h04, 6'h05, 6'h15, 6'h13, 6'h02, 6'h13,
    6'h14, 6'h11, 6'h05, 6'h12, 6'h10, 6'h11, 6'h13, 6'h15, 6'h14};
  localparam logic [0:N_IN-1][5:0] DEF_IN_SMALL = {
    6'h02, 6'h02, 6'h05, 6'h04, 6'h05, 6'h05, 6'h05, 6'h02, 6'h03,
    6'h05, 6'h01, 6'h00, 6'h05, 6'h01, 6'h02, 6'h03, 6'h01, 6'h00};

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_KEY1  = 3'b010,
    SEQ_ARMED = 3'b100
  } prl_seq_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } prl_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } prl_apb_rsp_type;

  typedef struct packed {
    logic       hit;
    logic       lock;
    logic       stat;
    logic       mem;
    logic       out;
    logic [4:0] idx;
  } prl_dec_type;

  typedef struct packed {
    logic [N_PIN-1:0] sync1;
    logic [N_PIN-1:0] sync2;
    prl_seq_type      seq;
    logic             locked;
    logic             clr_used;
    logic             set_used;
    logic             one_way;
    logic             cfg_taken;
    prl_apb_rsp_type  rsp;
    logic [N_IN-1:0]  periph_in;
    logic [N_PIN-1:0] pin_out;
    logic [N_PIN-1:0] bus_buf;
  } prl_state_type;

  localparam prl_state_type STATE_RESET = '{
    seq: SEQ_IDLE, default: '0};

endpackage

// ### prl_sel_mem.sv
module prl_sel_mem
  import prl_pkg::*;
#(
  parameter int                             DEPTH = N_WORD,
  parameter int                             WIDTH = SEL_W,
  parameter logic [0:DEPTH-1][WIDTH-1:0]    INIT  = '0
) (
  input  wire logic                         i_clk,    // system clock
  input  wire logic                         i_srst,   // power-on reset
  input  wire logic                         i_we,     // write strobe
  input  wire logic [4:0]                   i_waddr,  // write word
  input  wire logic [WIDTH-1:0]             i_wdata,  // write value
  input  wire logic [4:0]                   i_raddr,  // read word
  output logic      [WIDTH-1:0]             o_rdata,  // registered read
  output logic      [0:DEPTH-1][WIDTH-1:0]  o_words   // all words, for routing
);

  typedef struct packed {
    logic [0:DEPTH-1][WIDTH-1:0] words;
    logic [WIDTH-1:0]            rdata;
  } prl_mem_state_type;

  prl_mem_state_type mem_q;
  prl_mem_state_type mem_d;

  initial begin
    if (DEPTH > 32 || DEPTH < 1) begin
      $error("prl_sel_mem: depth must be 1 to 32");
    end
  end

  // write port and registered read port
  always_comb begin
    mem_d       = mem_q;
    mem_d.rdata = mem_q.words[i_raddr];
    if (i_we) begin
      mem_d.words[i_waddr] = i_wdata;
    end
  end

  // only power-on returns the words to their defaults
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mem_q <= '{words: INIT, rdata: '0};
    end else begin
      mem_q <= mem_d;
    end
  end

  assign o_rdata = mem_q.rdata;
  assign o_words = mem_q.words;

endmodule

// ### prl_routing_lock.sv
// The APB register port and the register addresses were decided locally.
module prl_routing_lock
  import prl_pkg::*;
#(
  parameter bit                 LARGE     = 1'b1,         // port C present
  parameter logic [N_PIN-1:0]   BUS_PINS  = 14'h0003      // pins with bus buffers
) (
  input  wire logic             i_clk,          // system clock, 200 MHz
  input  wire logic             i_srst,         // power-on reset, sync, high
  input  wire logic             i_dev_rst,      // any other device reset
  input  wire logic             i_one_shot_cfg, // one_shot_lock_setting strap
  input  wire logic             i_bus_mode,     // two-wire bus mode active
  input  wire prl_apb_req_type  i_apb,          // apb request
  output prl_apb_rsp_type       o_apb,          // apb answer
  input  wire logic [N_PIN-1:0] i_pins,         // pad inputs, A0-5 then C0-7
  output logic      [N_IN-1:0]  o_periph_in,    // routed peripheral inputs
  input  wire logic [31:0]      i_periph_out,   // sources by code, bit 0 latch
  output logic      [N_PIN-1:0] o_pin_out,      // routed pin data
  output logic      [N_PIN-1:0] o_bus_buf,      // pin uses bus-specific buffer
  output logic                  o_locked        // selections_locked_flag
);

  localparam int                          N_PIN_USED = LARGE ? N_PIN : N_PINA;
  localparam logic [0:N_WORD-1][SEL_W-1:0] MEM_INIT =
    {(LARGE ? DEF_IN_LARGE : DEF_IN_SMALL), {(N_WORD - N_IN){OUT_RESET}}};

  prl_state_type           st_q;
  prl_state_type           st_d;
  logic [SEL_W-1:0]        mem_rdata;
  logic [0:N_WORD-1][SEL_W-1:0] words;
  logic                    mem_we;
  logic [4:0]              mem_waddr;
  logic [SEL_W-1:0]        mem_wdata;
  prl_dec_type             dec;
  logic                    wr_done;
  logic [N_IN-1:0]         st_d_in;

  initial begin
    if (N_IN + N_PIN > N_WORD) begin
      $error("prl_routing_lock: selection words exceed memory depth");
    end
  end

  // map a byte address onto the register set
  function automatic prl_dec_type decode(input logic [ADDR_W-1:0] a);
    prl_dec_type r;
    logic [ADDR_W-1:0] rel;
    r   = '0;
    rel = '0;
    if (a == OFF_LOCK) begin
      r.hit  = 1'b1;
      r.lock = 1'b1;
    end else if (a == OFF_STATUS) begin
      r.hit  = 1'b1;
      r.stat = 1'b1;
    end else if (a[1:0] == 2'b00 && a >= OFF_IN_BASE && a < OFF_OUT_BASE) begin
      rel = a - OFF_IN_BASE;
      if (rel[ADDR_W-1:2] < N_IN) begin
        r.hit = 1'b1;
        r.mem = 1'b1;
        r.idx = rel[6:2];
      end
    end else if (a[1:0] == 2'b00 && a >= OFF_OUT_BASE) begin
      rel = a - OFF_OUT_BASE;
      if (rel[ADDR_W-1:2] < N_PIN_USED) begin
        r.hit = 1'b1;
        r.mem = 1'b1;
        r.out = 1'b1;
        r.idx = 5'(N_IN) + rel[6:2];
      end
    end
    return r;
  endfunction

  // pad index to input pin code
  function automatic logic [5:0] pin_code(input int p);
    // port a low, port c at 0x10
    if (p < N_PINA) begin
      return 6'(p);
    end
    return CODE_PORTC | 6'(p - N_PINA);
  endfunction

  // input pin code to synchronised pad level; unsupported codes read low
  function automatic logic pick_pin(input logic [5:0] c, input logic [N_PIN-1:0] pv);
    logic r;
    r = 1'b0;
    for (int p = 0; p < N_PIN_USED; p++) begin
      if (c == pin_code(p)) begin
        r = pv[p];
      end
    end
    return r;
  endfunction

  assign dec     = decode(i_apb.paddr);
  assign wr_done = i_apb.psel & i_apb.penable & st_q.rsp.pready & i_apb.pwrite;

  // selection write path, blocked while locked
  always_comb begin
    mem_waddr = dec.idx;
    // six-bit input field, five-bit output field
    mem_wdata = i_apb.pwdata[SEL_W-1:0] & (dec.out ? OUT_SEL_MASK : IN_SEL_MASK);
    mem_we    = wr_done & dec.mem & ~st_q.locked;
  end

  // selections change only by bus write or power-on reset
  prl_sel_mem #(
    .DEPTH   (N_WORD),
    .WIDTH   (SEL_W),
    .INIT    (MEM_INIT)
  ) u_mem (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (dec.idx),
    .o_rdata (mem_rdata),
    .o_words (words)
  );

  // lock sequence, bus answer and routing
  always_comb begin
    st_d = st_q;

    // pads come from outside the clock domain: two flops first
    st_d.sync1 = i_pins;
    st_d.sync2 = st_q.sync1;

    // one-shot strap caught once after each reset
    if (!st_q.cfg_taken) begin
      st_d.one_way   = i_one_shot_cfg;
      st_d.cfg_taken = 1'b1;
    end

    // apb: answer in the second access cycle
    st_d.rsp.pready = i_apb.psel & i_apb.penable & ~st_q.rsp.pready;
    if (i_apb.psel && i_apb.penable && !st_q.rsp.pready) begin
      st_d.rsp.pslverr = ~dec.hit;
      st_d.rsp.prdata  = '0;
      if (!i_apb.pwrite) begin
        if (dec.lock) begin
          st_d.rsp.prdata[LOCK_BIT] = st_q.locked;
        end else if (dec.stat) begin
          st_d.rsp.prdata[3:0] = {st_q.set_used, st_q.clr_used,
                                  st_q.one_way, st_q.locked};
        end else if (dec.mem) begin
          st_d.rsp.prdata[SEL_W-1:0] = mem_rdata;
        end
      end
    end else if (!st_d.rsp.pready) begin
      st_d.rsp.pslverr = 1'b0;
    end

    if (wr_done) begin
      st_d.seq = SEQ_IDLE;
      if (dec.lock) begin
        case (st_q.seq)
          SEQ_IDLE: begin
            if (i_apb.pwdata[7:0] == UNLOCK_KEY1) begin
              st_d.seq = SEQ_KEY1;
            end
          end
          SEQ_KEY1: begin
            if (i_apb.pwdata[7:0] == UNLOCK_KEY2) begin
              st_d.seq = SEQ_ARMED;
            end
          end
          SEQ_ARMED: begin
            if (i_apb.pwdata[LOCK_BIT] && !st_q.locked) begin
              if (!(st_q.one_way && st_q.set_used)) begin
                st_d.locked   = 1'b1;
                st_d.set_used = 1'b1;
              end
            end else if (!i_apb.pwdata[LOCK_BIT] && st_q.locked) begin
              if (!(st_q.one_way && (st_q.clr_used || st_q.set_used))) begin
                st_d.locked   = 1'b0;
                st_d.clr_used = 1'b1;
              end
            end
          end
          default: begin
            st_d.seq = SEQ_IDLE;
          end
        endcase
      end
    end

    // second comparator code only when large
    for (int p = 0; p < N_PIN; p++) begin
      if (p < N_PIN_USED && (LARGE || words[N_IN + p][OUT_W-1:0] != OUT_CMP2)) begin
        st_d.pin_out[p] = i_periph_out[words[N_IN + p][OUT_W-1:0]];
      end else begin
        st_d.pin_out[p] = 1'b0;
      end
    end

    // bus buffer only on dedicated pins
    for (int p = 0; p < N_PIN; p++) begin
      st_d.bus_buf[p] = i_bus_mode & BUS_PINS[p] & (p < N_PIN_USED) &
                        ((words[IDX_BUS_CLK] == pin_code(p)) ||
                         (words[IDX_BUS_DAT] == pin_code(p)));
    end

    // other device resets drop the lock state but not the selections
    if (i_dev_rst) begin
      st_d.seq       = SEQ_IDLE;
      st_d.locked    = 1'b0;
      st_d.clr_used  = 1'b0;
      st_d.set_used  = 1'b0;
      st_d.cfg_taken = 1'b0;
      st_d.rsp       = '0;
    end
  end

  // input routing, one mux per peripheral input
  // software pairs in and out selections
  for (genvar g = 0; g < N_IN; g++) begin : g_in
    always_comb begin
      st_d_in[g] = pick_pin(words[g], st_q.sync2);
    end
  end

  // power-on clears all lock state; st_d_in merged here
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= STATE_RESET;
    end else begin
      st_q           <= st_d;
      st_q.periph_in <= st_d_in;
    end
  end

  assign o_apb       = st_q.rsp;
  assign o_periph_in = st_q.periph_in;
  assign o_pin_out   = st_q.pin_out;
  assign o_bus_buf   = st_q.bus_buf;
  assign o_locked    = st_q.locked;

endmodule

// ### prl_routing_lock_chk.sv
module prl_routing_lock_chk
  import prl_pkg::*;
#(
  parameter logic [N_PIN-1:0] BUS_PINS = 14'h0003  // pins with bus buffers
) (
  input wire logic             i_clk,         // clock
  input wire logic             i_srst,        // power-on reset
  input wire logic             i_dev_rst,     // other reset
  input wire logic             i_one_shot_cfg,// one-shot strap
  input wire prl_apb_req_type  i_apb,         // apb request
  input wire prl_apb_rsp_type  o_apb,         // apb answer
  input wire logic [31:0]      i_periph_out,  // output sources
  input wire logic [N_PIN-1:0] o_pin_out,     // routed pins
  input wire logic [N_PIN-1:0] o_bus_buf,     // buffer kind
  input wire logic             o_locked       // lock flag
);
  logic        done_w;
  logic        rd_done;
  logic        wr_lock;
  logic [11:0] a;
  // completed transfers, decoded once for all properties
  assign done_w  = i_apb.psel && i_apb.penable && o_apb.pready;
  assign rd_done = done_w && !i_apb.pwrite;
  assign wr_lock = done_w && i_apb.pwrite && i_apb.paddr == OFF_LOCK;
  assign a       = i_apb.paddr;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst || i_dev_rst);
  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_key1;
    wr_lock && i_apb.pwdata[7:0] == UNLOCK_KEY1 && !i_one_shot_cfg;
  endsequence
  sequence s_key2;
    wr_lock && i_apb.pwdata[7:0] == UNLOCK_KEY2;
  endsequence
  a_ready_timing: assert property (s_setup |=> !o_apb.pready ##1 o_apb.pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("pready longer than one cycle");
  a_insel_width: assert property (
    rd_done && a >= OFF_IN_BASE && a < OFF_IN_BASE + 12'h048 |-> o_apb.prdata[31:6] == '0)
    else $error("input select upper bits set");
  a_outsel_width: assert property (
    rd_done && a >= OFF_OUT_BASE && a < OFF_OUT_BASE + 12'h038 |-> o_apb.prdata[31:5] == '0)
    else $error("output select upper bits set");
  a_lock_read: assert property (
    rd_done && a == OFF_LOCK |-> o_apb.prdata == {31'h0, o_locked})
    else $error("lock read differs from flag");
  a_lock_cause: assert property (
    $changed(o_locked) |-> $past(wr_lock) || $past(wr_lock, 2) || $past(i_srst) || $past(i_dev_rst))
    else $error("lock flag moved without lock write");
  a_reset_unlock: assert property ($past(i_srst) || $past(i_dev_rst) |-> !o_locked)
    else $error("lock flag set after reset");
  a_bus_buf_pins: assert property ((o_bus_buf & ~BUS_PINS) == '0)
    else $error("bus buffer on a generic pin");
  a_key_set: assert property (
    s_key1 ##4 s_key2 ##4 (wr_lock && i_apb.pwdata[0]) |-> ##[1:2] o_locked)
    else $error("key sequence did not lock");
  a_key_clear: assert property (
    s_key1 ##4 s_key2 ##4 (wr_lock && !i_apb.pwdata[0]) |-> ##[1:2] !o_locked)
    else $error("key sequence did not unlock");
  a_lock_hold: assert property (
    o_locked && $stable(i_periph_out) ##1 o_locked && $stable(i_periph_out)
      |=> $stable(o_pin_out))
    else $error("pin routing moved while locked");
endmodule

bind prl_routing_lock prl_routing_lock_chk #(.BUS_PINS(BUS_PINS)) u_chk (
  .i_clk, .i_srst, .i_dev_rst, .i_one_shot_cfg, .i_apb, .o_apb,
  .i_periph_out, .o_pin_out, .o_bus_buf, .o_locked);

// ### prl_periph_model.sv
module prl_periph_model
  import prl_pkg::*;
(
  input  wire logic             i_flip,  // invert every source
  output logic      [31:0]      o_src,   // peripheral outputs by code
  output logic      [N_PIN-1:0] o_pads   // pad levels
);
  timeunit 1ns;
  timeprecision 100ps;
  // fixed patterns; flipping lets every routed bit be seen at both levels
  assign o_src  = i_flip ? ~32'h5a3c96e1 : 32'h5a3c96e1;
  assign o_pads = i_flip ? ~14'h2b4d : 14'h2b4d;
endmodule

// ### prl_routing_lock_test.sv
module prl_routing_lock_test
  import prl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_srst = 1'b1, i_dev_rst = 1'b0, cfg = 1'b0, flip = 1'b0, lkd = 1'b0;
  prl_apb_req_type req = '0;
  prl_apb_rsp_type rsp;
  logic [31:0]      src, q;
  logic [N_PIN-1:0] pads, pin_o;
  logic [N_IN-1:0]  pin_i;
  logic             e, bm = 1'b0;
  logic             lk;
  logic [N_PIN-1:0] bbuf;
  logic [5:0]       isel [N_IN];
  logic [5:0]       osel [N_PIN];
  int               errors = 0, n_checks = 0;
  localparam logic [5:0] OC [N_PIN] = '{6'h1b, 6'h19, 6'h16, 6'h14, 6'h00, 6'h1a, 6'h01,
    6'h15, 6'h13, 6'h10, 6'h0f, 6'h0e, 6'h05, 6'h0a};
  always #2.5 i_clk = ~i_clk;
  prl_routing_lock #(.LARGE(1'b1), .BUS_PINS(14'h0003)) i_dut (.i_clk(i_clk),
    .i_srst(i_srst), .i_dev_rst(i_dev_rst), .i_one_shot_cfg(cfg), .i_bus_mode(bm),
    .i_apb(req), .o_apb(rsp), .i_pins(pads), .o_periph_in(pin_i), .i_periph_out(src),
    .o_pin_out(pin_o), .o_bus_buf(bbuf), .o_locked(lk));
  prl_periph_model i_src (.i_flip(flip), .o_src(src), .o_pads(pads));
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // one apb transfer; request held until pready is sampled
  task automatic apb(input bit w, input int a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{1'b1, 1'b0, w, 12'(a), d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    // pready is read at the rising edge itself, before that edge updates it
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) errors++;
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rd(input int a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic key(input logic [31:0] v);
    apb(1'b1, OFF_LOCK, 32'h55);
    apb(1'b1, OFF_LOCK, 32'haa);
    apb(1'b1, OFF_LOCK, v);
  endtask
  // upper bits written as ones so the write mask is exercised
  task automatic sel(input bit o, input int i, input logic [5:0] c);
    apb(1'b1, int'(o ? OFF_OUT_BASE : OFF_IN_BASE) + 4 * i, (o ? 32'hffffffe0 : 32'hffffffc0) | c);
    if (!lkd && o) osel[i] = c;
    if (!lkd && !o) isel[i] = c;
  endtask
  task automatic sel_all();
    for (int i = 0; i < N_IN; i++) rd(int'(OFF_IN_BASE) + 4 * i, 32'(isel[i]));
    for (int p = 0; p < N_PIN; p++) rd(int'(OFF_OUT_BASE) + 4 * p, 32'(osel[p]));
  endtask
  task automatic route();
    logic [N_PIN-1:0] ep;
    logic [N_IN-1:0]  ei;
    for (int f = 0; f < 2; f++) begin
      @(posedge i_clk);
      flip <= f[0];
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      for (int p = 0; p < N_PIN; p++) ep[p] = src[osel[p]];
      for (int i = 0; i < N_IN; i++) ei[i] = isel[i] < 6 ? pads[isel[i]] : pads[isel[i] - 6'd10];
      chk(32'(pin_o), 32'(ep));
      chk(32'(pin_i), 32'(ei));
    end
  endtask
  task automatic reset(input bit por);
    @(posedge i_clk);
    if (por) i_srst <= 1'b1;
    else i_dev_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    i_dev_rst <= 1'b0;
    lkd = 1'b0;
    for (int i = 0; i < N_IN && por; i++) isel[i] = DEF_IN_LARGE[i];
    for (int p = 0; p < N_PIN && por; p++) osel[p] = 6'h00;
  endtask
  // main sequence
  initial begin
    reset(1'b1);
    sel_all();
    rd(OFF_LOCK, 32'h0);
    apb(1'b0, 12'h300, 32'h0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    // only supported pin codes are used
    for (int i = 0; i < N_IN; i++) sel(1'b0, i, i % 2 ? 6'h10 + 6'(i % 6) : 6'(i % 6));
    for (int p = 0; p < N_PIN; p++) sel(1'b1, p, OC[p]);
    sel(1'b0, IDX_BUS_DAT, 6'h02);
    sel_all();
    route();
    apb(1'b1, OFF_LOCK, 32'h1);
    rd(OFF_LOCK, 32'h0);
    key(32'h1);
    lkd = 1'b1;
    rd(OFF_LOCK, 32'h1);
    chk(32'(lk), 32'h1);
    sel(1'b0, 0, 6'h05);
    sel(1'b1, 0, 6'h00);
    sel_all();
    route();
    apb(1'b1, OFF_LOCK, 32'h55);
    apb(1'b1, OFF_IN_BASE, 32'h3);
    apb(1'b1, OFF_LOCK, 32'haa);
    apb(1'b1, OFF_LOCK, 32'h0);
    rd(OFF_LOCK, 32'h1);
    apb(1'b1, OFF_LOCK, 32'h55);
    apb(1'b1, OFF_LOCK, 32'hab);
    apb(1'b1, OFF_LOCK, 32'h0);
    rd(OFF_LOCK, 32'h1);
    key(32'h0);
    lkd = 1'b0;
    rd(OFF_LOCK, 32'h0);
    sel(1'b0, 0, 6'h05);
    // bus clock on a dedicated pin, bus data on a generic one
    bm <= 1'b1;
    sel(1'b0, IDX_BUS_CLK, 6'h00);
    sel(1'b0, IDX_BUS_DAT, 6'h05);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk(32'(bbuf), 32'h1);
    reset(1'b0);
    sel_all();
    cfg <= 1'b1;
    reset(1'b0);
    key(32'h0);
    key(32'h1);
    lkd = 1'b1;
    key(32'h0);
    rd(OFF_LOCK, 32'h1);
    rd(OFF_STATUS, 32'hb);
    sel(1'b1, 1, 6'h01);
    sel_all();
    reset(1'b1);
    sel_all();
    key(32'h1);
    rd(OFF_STATUS, 32'hb);
    conclude();
  end
  // hang guard, far beyond the roughly 1100 cycles the run needs
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    conclude();
  end
endmodule
